/* bidir_port_consts.svh */
// Purpose: Constants for the bidirectional handshake port.
// Assumes: One system clock; all port inputs synchronous to it.
// Notes:   Reset values apply to the holding registers and flags.
`ifndef BIDIR_PORT_CONSTS_SVH
`define BIDIR_PORT_CONSTS_SVH

`define PORT_WIDTH       8
`define HOLD_RESET       8'h00
`define FLAG_RESET       1'b0
`define INVERT_DEFAULT   1'b0
`define BUF_DEPTH        2

`endif

/* bidir_port_pkg.sv */
// Purpose: Types for the bidirectional handshake port.
// Assumes: Width fixed by the constants header.
// Notes:   None.
`include "bidir_port_consts.svh"

package bidir_port_pkg;

  typedef logic [`PORT_WIDTH-1:0] port_word_t;

  // State of one transfer direction.
  typedef struct packed {
    logic       clk_prev;
    logic       clr_prev;
    logic       full;
  } dir_state_t;

endpackage : bidir_port_pkg

/* hold_buffer.sv */
// Purpose: Two-entry buffer holding words of one transfer direction.
// Assumes: Single clock, active-low asynchronous reset.
// Notes:   Drain side may stall; ready on the fill side reflects space.
`timescale 1ns/1ps
`include "bidir_port_consts.svh"

module hold_buffer
  import bidir_port_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  if (WIDTH < 1) begin : g_bad_width
    $error("hold_buffer width must be at least one");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0]            cnt;
  } buf_state_t;

  buf_state_t st;
  buf_state_t next_st;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic push;
    logic pop;
    push    = 1'b0;
    pop     = 1'b0;
    next_st = st;
    push    = in_valid && (st.cnt != 2'd2);
    pop     = (st.cnt != 2'd0) && out_ready;
    if (pop) begin
      next_st.slot[0] = st.slot[1];
    end
    if (push) begin
      if (st.cnt == 2'd0 || (st.cnt == 2'd1 && pop)) begin
        next_st.slot[0] = in_data;
      end else begin
        next_st.slot[1] = in_data;
      end
    end
    next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready  = (st.cnt != 2'd2);
  assign out_valid = (st.cnt != 2'd0);
  assign out_data  = st.slot[0];

  no_overflow_a : assert property (@(posedge clock) disable iff (!rst_b)
    st.cnt <= 2'd2)
    else $error("buffer count above two");

  empty_fill_a : assert property (@(posedge clock) disable iff (!rst_b)
    (st.cnt == 2'd0 && in_valid) |=> out_valid && out_data == $past(in_data))
    else $error("word into empty buffer not shown");

endmodule : hold_buffer

/* bidir_handshake_io_port.sv */
// Purpose: Eight-bit bidirectional port with handshake full flags.
// Assumes: Load clocks and clears are synchronous levels; edges found
//          by comparing with the previous sample.
// Notes:   Pins are split into input, output and active-low enable.
`timescale 1ns/1ps
`include "bidir_port_consts.svh"

module bidir_handshake_io_port
  import bidir_port_pkg::*;
#(
  parameter int WIDTH  = `PORT_WIDTH,
  parameter bit INVERT = `INVERT_DEFAULT
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] port_a_lines_in,
  output logic      [WIDTH-1:0] port_a_lines_out,
  output logic                  port_a_lines_oe_n,
  input  wire logic [WIDTH-1:0] port_b_lines_in,
  output logic      [WIDTH-1:0] port_b_lines_out,
  output logic                  port_b_lines_oe_n,
  input  wire logic             a_to_b_load_clock,
  input  wire logic             a_to_b_load_enable_n,
  input  wire logic             b_side_drive_enable_n,
  input  wire logic             a_to_b_flag_clear,
  output logic                  a_to_b_full_flag,
  input  wire logic             b_to_a_load_clock,
  input  wire logic             b_to_a_load_enable_n,
  input  wire logic             a_side_drive_enable_n,
  input  wire logic             b_to_a_flag_clear,
  output logic                  b_to_a_full_flag,
  output logic                  a_to_b_load_ready,
  output logic                  b_to_a_load_ready
);

  if (WIDTH != `PORT_WIDTH) begin : g_bad_width
    $error("port width must equal the documented width");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic rise(input logic prev, input logic now);
    return !prev && now;
  endfunction : rise

  function automatic port_word_t polar(input port_word_t d);
    return INVERT ? ~d : d;
  endfunction : polar

  typedef struct packed {
    dir_state_t ab;
    dir_state_t ba;
    port_word_t a_out;
    port_word_t b_out;
    logic       a_oe_n;
    logic       b_oe_n;
    logic       ab_rdy;
    logic       ba_rdy;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic       ab_load;
  logic       ba_load;
  logic       ab_in_ready;
  logic       ba_in_ready;
  logic       ab_valid;
  logic       ba_valid;
  port_word_t ab_word;
  port_word_t ba_word;

  assign ab_load = rise(st.ab.clk_prev, a_to_b_load_clock) &&
                   !a_to_b_load_enable_n;
  assign ba_load = rise(st.ba.clk_prev, b_to_a_load_clock) &&
                   !b_to_a_load_enable_n;

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  // A lines feed the A-to-B store.
  hold_buffer #(.WIDTH(WIDTH)) ab_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (ab_load),
    .in_ready  (ab_in_ready),
    .in_data   (port_a_lines_in),
    .out_valid (ab_valid),
    .out_ready (ab_load && ab_valid),
    .out_data  (ab_word)
  );

  // B lines feed the B-to-A store.
  hold_buffer #(.WIDTH(WIDTH)) ba_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (ba_load),
    .in_ready  (ba_in_ready),
    .in_data   (port_b_lines_in),
    .out_valid (ba_valid),
    .out_ready (ba_load && ba_valid),
    .out_data  (ba_word)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ab.clk_prev = a_to_b_load_clock;
    next_st.ba.clk_prev = b_to_a_load_clock;
    next_st.ab.clr_prev = a_to_b_flag_clear;
    next_st.ba.clr_prev = b_to_a_flag_clear;
    if (rise(st.ab.clr_prev, a_to_b_flag_clear)) begin
      next_st.ab.full = 1'b0;
    end
    // a load sets the flag; set wins.
    if (ab_load) begin
      next_st.ab.full = 1'b1;
    end
    if (rise(st.ba.clr_prev, b_to_a_flag_clear)) begin
      next_st.ba.full = 1'b0;
    end
    // a load sets the flag; set wins.
    if (ba_load) begin
      next_st.ba.full = 1'b1;
    end
    // B side shows the A-to-B word.
    next_st.b_out  = polar(ab_load ? port_a_lines_in : ab_word);
    next_st.b_oe_n = b_side_drive_enable_n;
    // A side shows the B-to-A word.
    next_st.a_out  = polar(ba_load ? port_b_lines_in : ba_word);
    next_st.a_oe_n = a_side_drive_enable_n;
    next_st.ab_rdy = ab_in_ready;
    next_st.ba_rdy = ba_in_ready;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st        <= '0;
      st.a_out  <= polar(`HOLD_RESET);
      st.b_out  <= polar(`HOLD_RESET);
      st.a_oe_n <= 1'b1;
      st.b_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign port_a_lines_out  = st.a_out;
  assign port_a_lines_oe_n = st.a_oe_n;
  assign port_b_lines_out  = st.b_out;
  assign port_b_lines_oe_n = st.b_oe_n;
  assign a_to_b_full_flag  = st.ab.full;
  assign b_to_a_full_flag  = st.ba.full;
  assign a_to_b_load_ready = st.ab_rdy;
  assign b_to_a_load_ready = st.ba_rdy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence ab_edge_s;
    !a_to_b_load_clock ##1 a_to_b_load_clock;
  endsequence

  sequence ba_edge_s;
    !b_to_a_load_clock ##1 b_to_a_load_clock;
  endsequence

  ab_load_sets_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    (ab_edge_s ##0 !a_to_b_load_enable_n) |=> a_to_b_full_flag &&
      port_b_lines_out == polar($past(port_a_lines_in)))
    else $error("A-to-B load did not set flag or data");

  ab_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
    (a_to_b_load_enable_n && !rise(st.ab.clr_prev, a_to_b_flag_clear))
      |=> a_to_b_full_flag == $past(a_to_b_full_flag))
    else $error("A-to-B flag changed while held");

  b_drive_a : assert property (@(posedge clock) disable iff (!rst_b)
    port_b_lines_oe_n == $past(b_side_drive_enable_n))
    else $error("B drive enable not followed");

  ab_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
    (!a_to_b_flag_clear ##1 (a_to_b_flag_clear && !ab_load))
      |=> !a_to_b_full_flag)
    else $error("A-to-B flag not cleared");

  ba_load_sets_a : assert property (
    @(posedge clock) disable iff (!rst_b)
    (ba_edge_s ##0 !b_to_a_load_enable_n)
      |=> b_to_a_full_flag &&
      port_a_lines_out == polar($past(port_b_lines_in)))
    else $error("B-to-A load did not set flag or data");

  ba_hold_a : assert property (@(posedge clock) disable iff (!rst_b)
    (b_to_a_load_enable_n && !rise(st.ba.clr_prev, b_to_a_flag_clear))
      |=> b_to_a_full_flag == $past(b_to_a_full_flag))
    else $error("B-to-A flag changed while held");

  a_drive_a : assert property (@(posedge clock) disable iff (!rst_b)
    port_a_lines_oe_n == $past(a_side_drive_enable_n))
    else $error("A drive enable not followed");

  ba_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
    (!b_to_a_flag_clear ##1 (b_to_a_flag_clear && !ba_load))
      |=> !b_to_a_full_flag)
    else $error("B-to-A flag not cleared");

  level_clear_a : assert property (@(posedge clock) disable iff (!rst_b)
    (a_to_b_flag_clear && $past(a_to_b_flag_clear) && ab_load)
      |=> a_to_b_full_flag)
    else $error("level clear overrode a load");

endmodule : bidir_handshake_io_port

/* bus_side_model.sv */
// Purpose: Far-side bus party on one two-way port of the device.
// Assumes: The device drives the lines while its enable is low.
// Notes:   Lines nobody drives show a pattern that flips every cycle.
`timescale 1ns/1ps

module bus_side_model
  import bidir_port_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       drive_on,
  input  wire port_word_t drive_val,
  input  wire logic       dut_oe_n,
  input  wire port_word_t dut_out,
  output port_word_t      level
);
  port_word_t last = 8'h00;

  assign level = !dut_oe_n ? dut_out : (drive_on ? drive_val : ~last);

  always @(posedge clock) begin
    last <= level;
  end
endmodule : bus_side_model

/* testbench.sv */
// Purpose: Self-checking bench for the bidirectional handshake port.
// Assumes: Bench drives at rising edges; one cycle load latency.
// Notes:   A second instance is the inverting build.
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g)

module testbench;
  import bidir_port_pkg::*;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic [1:0] ld = 2'b00, en_n = 2'b11, clr = 2'b00, oe_n = 2'b11;
  logic [1:0] on = 2'b00;
  port_word_t drv [2] = '{8'h00, 8'h00};
  port_word_t expv [2] = '{8'h00, 8'h00};
  logic       flg [2] = '{1'b0, 1'b0};
  port_word_t a_w, b_w, a_o, b_o, a_o2, b_o2;
  logic       a_oe, b_oe, f_ab, f_ba, r_ab, r_ba;
  int         n_mismatch = 0;
  int         check_count = 0;

  initial forever #12.5 clock = ~clock;

  bus_side_model side_a (.clock(clock), .drive_on(on[0]), .drive_val(drv[0]),
    .dut_oe_n(a_oe), .dut_out(a_o), .level(a_w));
  bus_side_model side_b (.clock(clock), .drive_on(on[1]), .drive_val(drv[1]),
    .dut_oe_n(b_oe), .dut_out(b_o), .level(b_w));

  bidir_handshake_io_port dut (.clock(clock), .rst_b(rst_b),
    .port_a_lines_in(a_w), .port_a_lines_out(a_o), .port_a_lines_oe_n(a_oe),
    .port_b_lines_in(b_w), .port_b_lines_out(b_o), .port_b_lines_oe_n(b_oe),
    .a_to_b_load_clock(ld[0]), .a_to_b_load_enable_n(en_n[0]),
    .b_side_drive_enable_n(oe_n[0]), .a_to_b_flag_clear(clr[0]),
    .a_to_b_full_flag(f_ab), .b_to_a_load_clock(ld[1]),
    .b_to_a_load_enable_n(en_n[1]), .a_side_drive_enable_n(oe_n[1]),
    .b_to_a_flag_clear(clr[1]), .b_to_a_full_flag(f_ba),
    .a_to_b_load_ready(r_ab), .b_to_a_load_ready(r_ba));

  bidir_handshake_io_port #(.INVERT(1'b1)) inv_dut (.clock(clock),
    .rst_b(rst_b), .port_a_lines_in(a_w), .port_a_lines_out(a_o2),
    .port_a_lines_oe_n(), .port_b_lines_in(b_w), .port_b_lines_out(b_o2),
    .port_b_lines_oe_n(), .a_to_b_load_clock(ld[0]),
    .a_to_b_load_enable_n(en_n[0]), .b_side_drive_enable_n(oe_n[0]),
    .a_to_b_flag_clear(clr[0]), .a_to_b_full_flag(),
    .b_to_a_load_clock(ld[1]), .b_to_a_load_enable_n(en_n[1]),
    .a_side_drive_enable_n(oe_n[1]), .b_to_a_flag_clear(clr[1]),
    .b_to_a_full_flag(), .a_to_b_load_ready(), .b_to_a_load_ready());

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(string n, port_word_t e, port_word_t g);
    check_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask : chk

  // One strobe on direction d (0 is A to B), optional clear edge with it.
  task automatic xfer(int d, port_word_t v, logic e, logic c);
    int k;
    for (k = 0; k < 20 && (d ? r_ba : r_ab) !== 1'b1; k++) @(posedge clock);
    if (k == 20) begin
      n_mismatch++;
      finish_test();
    end
    @(posedge clock);
    oe_n[d] <= 1'b0;
    oe_n[1-d] <= 1'b1;
    on[d] <= 1'b1;
    on[1-d] <= 1'b0;
    drv[d] <= v;
    @(posedge clock);
    ld[d] <= 1'b1;
    en_n[d] <= e;
    if (c) clr[d] <= 1'b1;
    @(posedge clock);
    ld[d] <= 1'b0;
    en_n[d] <= 1'b1;
    if (c) clr[d] <= 1'b0;
    if (!e) begin
      expv[d] = v;
      flg[d] = 1'b1;
    end else if (c) begin
      flg[d] = 1'b0;
    end
    #1;
    `CHK("full flag", flg[d], d ? f_ba : f_ab);
    `CHK("held word", expv[d], d ? a_o : b_o);
    `CHK("inverted word", ~expv[d], d ? a_o2 : b_o2);
    `CHK("driven lines", expv[d], d ? a_w : b_w);
    `CHK("source enable", 1'b1, d ? b_oe : a_oe);
    `CHK("drive enable", 1'b0, d ? a_oe : b_oe);
    `CHK("load ready", 1'b1, d ? r_ba : r_ab);
  endtask : xfer

  // ----------------
  // Main sequence.
  // ----------------
  initial begin
    void'($urandom(32'h5faa));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    for (int d = 0; d < 2; d++) xfer(d, 8'h00, 1'b1, 1'b1);
    // load, hold attempt, then read and clear.
    for (int i = 0; i < 16; i++) begin
      xfer(i % 2, port_word_t'($urandom), 1'b0, 1'b0);
      xfer(i % 2, port_word_t'($urandom), 1'b1, 1'b0);
      xfer(i % 2, port_word_t'($urandom), 1'b1, 1'b1);
    end
    for (int d = 0; d < 2; d++) begin
      xfer(d, 8'hff, 1'b0, 1'b1);
      @(posedge clock);
      clr[d] <= 1'b1;
      flg[d] = 1'b0;
      xfer(d, 8'h00, 1'b0, 1'b0);
      repeat (3) @(posedge clock);
      #1;
      `CHK("flag under held clear", 1'b1, d ? f_ba : f_ab);
      @(posedge clock);
      clr[d] <= 1'b0;
      xfer(d, 8'ha5, 1'b1, 1'b1);
    end
    @(posedge clock);
    oe_n <= 2'b11;
    repeat (2) @(posedge clock);
    #1;
    `CHK("a enable off", 1'b1, a_oe);
    `CHK("b enable off", 1'b1, b_oe);
    finish_test();
  end
endmodule : testbench
